// File: ttc_pkg.sv
/*
 Constants, field positions and carrier types for the triple timer/counter.
 Assumes a single core clock where one machine cycle is one clock period.
*/
// Summary of operation
// RULE1: Three 16-bit timer/counters, each a high and low byte, timer or counter.
// RULE2: Timer operation advances the low byte once every machine cycle.
// RULE3: Counter operation samples the pin each cycle, counts on high-then-low.
// RULE4: A falling edge needs two machine cycles, so half clock rate at most.
// RULE5: The pin source holds each level at least one machine cycle.
// RULE6: Gating bit set: count only while interrupt pin high and run bit set.
// RULE7: Counter-select set counts pin edges; cleared counts the system clock.
// RULE8: Mode 00: high byte counts, low byte is a 5-bit prescaler.
// RULE9: Mode 01: high and low bytes cascade into one 16-bit counter.
// RULE10: Mode 10: low byte counts and reloads from high byte on overflow.
// RULE11: Mode 11: timer 1 stops; timer 0 splits into two 8-bit counters.
// RULE12: Mode fields at bits 5:4 and 1:0; mode register resets to zero.
// RULE13: Run bit set by software enables counting, cleared halts it.
// RULE14: Overflow sets the flag; vectoring to the service routine clears it. Timer 2 has no acknowledge input; its flag clears only by a register write.
// RULE15: 16-bit mode wraps all ones to zero and overflows that same cycle.
package ttc_pkg;
    // Special function register addresses
    localparam logic [7:0] ADDR_T01_CTRL = 8'h88;
    localparam logic [7:0] ADDR_T01_MODE = 8'h89;
    localparam logic [7:0] ADDR_T0_LOW   = 8'h8A;
    localparam logic [7:0] ADDR_T1_LOW   = 8'h8B;
    localparam logic [7:0] ADDR_T0_HIGH  = 8'h8C;
    localparam logic [7:0] ADDR_T1_HIGH  = 8'h8D;
    localparam logic [7:0] ADDR_T2_CTRL  = 8'hC8;
    localparam logic [7:0] ADDR_T2_RLD_L = 8'hCA;
    localparam logic [7:0] ADDR_T2_RLD_H = 8'hCB;
    localparam logic [7:0] ADDR_T2_LOW   = 8'hCC;
    localparam logic [7:0] ADDR_T2_HIGH  = 8'hCD;
    // Control register bits
    localparam int TF1_BIT = 7;
    localparam int TR1_BIT = 6;
    localparam int TF0_BIT = 5;
    localparam int TR0_BIT = 4;
    // Mode register bits
    localparam int TIMER1_GATING_BIT_BIT = 7;
    localparam int CSEL1_BIT = 6;
    localparam int MODE1_LSB = 4;
    localparam int TIMER0_GATING_BIT_BIT = 3;
    localparam int CSEL0_BIT = 2;
    localparam int MODE0_LSB = 0;
    // Timer 2 control bits
    localparam int TF2_BIT   = 7;
    localparam int TR2_BIT   = 2;
    localparam int CSEL2_BIT = 1;
    // Reset values and count constants
    localparam logic [7:0]  MODE_RST  = 8'h00;
    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [7:0]  COUNT_RST = 8'h00;
    localparam logic [7:0]  BYTE_ONES = 8'hFF;
    localparam logic [7:0]  BYTE_ONE  = 8'h01;
    localparam logic [15:0] WORD_ONE  = 16'h0001;
    localparam logic [7:0]  RD_NONE   = 8'h00;

    typedef enum logic [1:0] {
        TTC_MODE_13     = 2'b00,
        TTC_MODE_16     = 2'b01,
        TTC_MODE_RELOAD = 2'b10,
        TTC_MODE_SPLIT  = 2'b11
    } ttc_mode_t;

    // Register write request from the core
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ttc_sfr_req_t;

    // External pins, all synchronous to clk
    typedef struct packed {
        logic [2:0] count_pin;
        logic       ext_irq1_pin;
        logic       ext_irq0_pin;
    } ttc_pins_t;
endpackage : ttc_pkg

// File: ttc_top.sv
/*
 Triple timer/counter: timers 0 and 1 with four modes, timer 2 auto-reload.
 Assumes register writes and reads arrive on the core register port, and
 that interrupt vectoring is signalled by one-cycle acknowledge pulses.
*/
`timescale 1ns/100ps
module ttc_top
    import ttc_pkg::*;
#(
    parameter int PRESCALE_BITS = 5
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire ttc_sfr_req_t sfr_req,
    output logic [7:0]        sfr_rdata,
    input  wire ttc_pins_t    pins,
    input  wire logic         isr_ack_t0,
    input  wire logic         isr_ack_t1,
    output logic              timer0_overflow_flag,
    output logic              timer1_overflow_flag,
    output logic              timer2_overflow_flag,
    output logic              timer1_ovf_pulse,
    output logic              timer2_ovf_pulse
);
    localparam int PS = PRESCALE_BITS;

    // Prescaler must leave at least one bit above it in the low byte
    if (PS < 1 || PS > 7) begin : g_bad_ps
        $error("PRESCALE_BITS must be 1 to 7");
    end

    logic [7:0] timer01_control, timer01_mode, timer2_control;
    logic [7:0] tl0, th0, tl1, th1, tl2, th2, rl2, rh2;
    logic [2:0] smp, prv;

    // One counting step: returns {overflow, high, low}
    function automatic logic [16:0] tc_step(input ttc_mode_t m,
                                            input logic [7:0] lo,
                                            input logic [7:0] hi,
                                            input logic       inc);
        logic [8+PS:0] p;
        logic [16:0]   w;
        logic [8:0]    l9;
        begin
            p  = {1'b0, hi, lo[PS-1:0]} + (PS+9)'(1);
            w  = {1'b0, hi, lo} + 17'(WORD_ONE);
            l9 = {1'b0, lo} + 9'(BYTE_ONE);
            tc_step = {1'b0, hi, lo};
            if (inc) begin
                case (m)
                    TTC_MODE_13:                                  // RULE8
                        tc_step = {p[8+PS], p[7+PS:PS], lo[7:PS],
                                   p[PS-1:0]};
                    TTC_MODE_16:                                  // RULE9
                        tc_step = w;                              // RULE15
                    TTC_MODE_RELOAD:                              // RULE10
                        tc_step = {l9[8], hi, l9[8] ? hi : l9[7:0]};
                    default:
                        tc_step = {l9[8], hi, l9[7:0]};
                endcase
            end
        end
    endfunction : tc_step

    // Address decode
    wire wr      = sfr_req.wr;
    wire wr_timer01_control = wr && sfr_req.addr == ADDR_T01_CTRL;
    wire wr_timer01_mode = wr && sfr_req.addr == ADDR_T01_MODE;
    wire wr_tl0  = wr && sfr_req.addr == ADDR_T0_LOW;
    wire wr_tl1  = wr && sfr_req.addr == ADDR_T1_LOW;
    wire wr_th0  = wr && sfr_req.addr == ADDR_T0_HIGH;
    wire wr_th1  = wr && sfr_req.addr == ADDR_T1_HIGH;
    wire wr_t2c  = wr && sfr_req.addr == ADDR_T2_CTRL;
    wire wr_rl2  = wr && sfr_req.addr == ADDR_T2_RLD_L;
    wire wr_rh2  = wr && sfr_req.addr == ADDR_T2_RLD_H;
    wire wr_tl2  = wr && sfr_req.addr == ADDR_T2_LOW;
    wire wr_th2  = wr && sfr_req.addr == ADDR_T2_HIGH;
    wire [7:0] wd = sfr_req.wdata;

    // Falling edge: previous sample high, current sample low
    wire [2:0] fall = prv & ~smp;                                 // RULE3

    // Mode register fields
    wire ttc_mode_t m0 = ttc_mode_t'(timer01_mode[MODE0_LSB+1:MODE0_LSB]); // RULE12
    wire ttc_mode_t m1 = ttc_mode_t'(timer01_mode[MODE1_LSB+1:MODE1_LSB]); // RULE12
    wire timer0_gating_bit = timer01_mode[TIMER0_GATING_BIT_BIT];
    wire timer1_gating_bit = timer01_mode[TIMER1_GATING_BIT_BIT];
    wire csel0 = timer01_mode[CSEL0_BIT];
    wire csel1 = timer01_mode[CSEL1_BIT];
    wire csel2 = timer2_control[CSEL2_BIT];
    wire tr0   = timer01_control[TR0_BIT];
    wire tr1   = timer01_control[TR1_BIT];
    wire tr2   = timer2_control[TR2_BIT];

    // Run qualification with optional gating by the interrupt pins
    wire run0 = tr0 && (!timer0_gating_bit || pins.ext_irq0_pin);      // RULE6 RULE13
    wire run1 = tr1 && (!timer1_gating_bit || pins.ext_irq1_pin);      // RULE6 RULE13
    wire inc0 = run0 && (csel0 ? fall[0] : 1'b1);          // RULE2 RULE7
    wire inc1 = run1 && (csel1 ? fall[1] : 1'b1) &&
                m1 != TTC_MODE_SPLIT;                      // RULE7 RULE11
    wire inc2 = tr2 && (csel2 ? fall[2] : 1'b1);           // RULE1

    // Timers 0 and 1 step results
    wire [16:0] st0 = tc_step(m0, tl0, th0, inc0);
    wire [16:0] st1 = tc_step(m1, tl1, th1, inc1);
    wire split0 = m0 == TTC_MODE_SPLIT;
    // Split high byte of timer 0 counts machine cycles under timer 1 run
    wire inc0h  = split0 && tr1;                                  // RULE11
    wire ovf0   = st0[16];
    wire ovf0h  = inc0h && th0 == BYTE_ONES;
    wire ovf1   = st1[16];
    // Timer 1 flag is taken by the split high byte of timer 0
    wire set_tf1 = split0 ? ovf0h : ovf1;                        // RULE11

    // Timer 2: 16-bit count, reload from the reload pair on overflow
    wire [16:0] sum2 = {1'b0, th2, tl2} + 17'(WORD_ONE);
    wire        ovf2 = inc2 && sum2[16];
    wire [15:0] cnt2 = ovf2 ? {rh2, rl2} : (inc2 ? sum2[15:0] : {th2, tl2});

    // Next values, software write taking priority over counting
    wire [7:0] next_tl0 = wr_tl0 ? wd : st0[7:0];
    wire [7:0] next_th0 = wr_th0 ? wd :
                          (split0 ? th0 + (inc0h ? BYTE_ONE : 8'h00)
                                  : st0[15:8]);
    wire [7:0] next_tl1 = wr_tl1 ? wd : st1[7:0];
    wire [7:0] next_th1 = wr_th1 ? wd : st1[15:8];
    wire [7:0] next_tl2 = wr_tl2 ? wd : cnt2[7:0];
    wire [7:0] next_th2 = wr_th2 ? wd : cnt2[15:8];
    wire [7:0] next_timer01_mode = wr_timer01_mode ? wd : timer01_mode;

    // Flags: hardware set wins over software write and vector clear
    logic [7:0] next_timer01_control, next_timer2_control;
    always_comb begin
        next_timer01_control = wr_timer01_control ? wd : timer01_control;
        if (isr_ack_t0)
            next_timer01_control[TF0_BIT] = 1'b0;                            // RULE14
        if (isr_ack_t1)
            next_timer01_control[TF1_BIT] = 1'b0;                            // RULE14
        if (ovf0)
            next_timer01_control[TF0_BIT] = 1'b1;                            // RULE14
        if (set_tf1)
            next_timer01_control[TF1_BIT] = 1'b1;                            // RULE14
        next_timer2_control = wr_t2c ? wd : timer2_control;
        if (ovf2)
            next_timer2_control[TF2_BIT] = 1'b1;
    end

    // Read data select; unmapped addresses read zero
    wire [7:0] a = sfr_req.addr;
    wire [7:0] next_rdata =
        (a == ADDR_T01_CTRL) ? timer01_control  : (a == ADDR_T01_MODE) ? timer01_mode  :
        (a == ADDR_T0_LOW)   ? tl0   : (a == ADDR_T1_LOW)   ? tl1   :
        (a == ADDR_T0_HIGH)  ? th0   : (a == ADDR_T1_HIGH)  ? th1   :
        (a == ADDR_T2_CTRL)  ? timer2_control : (a == ADDR_T2_RLD_L) ? rl2   :
        (a == ADDR_T2_RLD_H) ? rh2   : (a == ADDR_T2_LOW)   ? tl2   :
        (a == ADDR_T2_HIGH)  ? th2   : RD_NONE;

    // Pin samples, one per machine cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            smp <= 3'h0;
            prv <= 3'h0;
        end else begin
            smp <= pins.count_pin;                                // RULE3
            prv <= smp;                                           // RULE4
        end
    end

    // Control and mode registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer01_control  <= CTRL_RST;
            timer01_mode  <= MODE_RST;                                    // RULE12
            timer2_control <= CTRL_RST;
        end else begin
            timer01_control  <= next_timer01_control;
            timer01_mode  <= next_timer01_mode;
            timer2_control <= next_timer2_control;
        end
    end

    // Count and reload bytes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {tl0, th0, tl1, th1} <= {4{COUNT_RST}};
            {tl2, th2, rl2, rh2} <= {4{COUNT_RST}};
        end else begin
            tl0 <= next_tl0;
            th0 <= next_th0;
            tl1 <= next_tl1;
            th1 <= next_th1;
            tl2 <= next_tl2;
            th2 <= next_th2;
            rl2 <= wr_rl2 ? wd : rl2;
            rh2 <= wr_rh2 ? wd : rh2;
        end
    end

    // Registered read data and overflow pulses
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sfr_rdata        <= RD_NONE;
            timer1_ovf_pulse <= 1'b0;
            timer2_ovf_pulse <= 1'b0;
        end else begin
            sfr_rdata        <= next_rdata;
            timer1_ovf_pulse <= ovf1;
            timer2_ovf_pulse <= ovf2;
        end
    end

    // Flags straight from the control registers
    assign timer0_overflow_flag = timer01_control[TF0_BIT];
    assign timer1_overflow_flag = timer01_control[TF1_BIT];
    assign timer2_overflow_flag = timer2_control[TF2_BIT];

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_hi_lo;
        smp[0] ##1 !smp[0];
    endsequence
    sequence s_no_wr0;
        !wr_tl0 && !wr_th0;
    endsequence

    property p_timer_tick;
        (m0 == TTC_MODE_16 && run0 && !csel0 && tl0 != BYTE_ONES)
            ##0 s_no_wr0 |=> tl0 == $past(tl0) + BYTE_ONE;
    endproperty
    a_timer_tick: assert property (p_timer_tick) // RULE2
        else $error("timer mode did not advance low byte");

    property p_pin_count;
        (m1 == TTC_MODE_16 && run1 && csel1 && fall[1] && !wr_tl1 &&
         !wr_th1 && tl1 != BYTE_ONES) |=> tl1 == $past(tl1) + BYTE_ONE;
    endproperty
    a_pin_count: assert property (p_pin_count) // RULE3
        else $error("pin edge did not advance low byte");

    property p_edge_two;
        s_hi_lo |-> fall[0] ##1 !fall[0];
    endproperty
    a_edge_two: assert property (p_edge_two) // RULE4
        else $error("edge detect timing wrong");

    property p_gate_hold;
        (timer0_gating_bit && !pins.ext_irq0_pin) ##0 s_no_wr0 |=> $stable(tl0);
    endproperty
    a_gate_hold: assert property (p_gate_hold) // RULE6
        else $error("gated timer counted with pin low");

    property p_prescale;
        (m0 == TTC_MODE_13 && !wr_tl0) |=> $stable(tl0[7:PS]);
    endproperty
    a_prescale: assert property (p_prescale) // RULE8
        else $error("prescaler upper bits changed");

    property p_reload;
        (m1 == TTC_MODE_RELOAD && inc1 && tl1 == BYTE_ONES &&
         !wr_tl1 && !wr_th1) |=> tl1 == $past(th1);
    endproperty
    a_reload: assert property (p_reload) // RULE10
        else $error("reload value not taken");

    property p_t1_stop;
        (m1 == TTC_MODE_SPLIT && !wr_tl1 && !wr_th1) |=> $stable({th1, tl1});
    endproperty
    a_t1_stop: assert property (p_t1_stop) // RULE11
        else $error("timer 1 counted in stop mode");

    property p_mode_hold;
        !wr_timer01_mode |=> $stable(timer01_mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) // RULE12
        else $error("mode register changed without write");

    property p_run_off;
        !tr0 ##0 s_no_wr0 |=> $stable(tl0);
    endproperty
    a_run_off: assert property (p_run_off) // RULE13
        else $error("timer counted with run bit clear");

    property p_flag_set;
        ovf0 |=> timer0_overflow_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) // RULE14
        else $error("overflow flag not set");

    property p_flag_clr;
        (isr_ack_t0 && !ovf0) |=> !timer0_overflow_flag;
    endproperty
    a_flag_clr: assert property (p_flag_clr) // RULE14
        else $error("overflow flag not cleared on vector");

    property p_wrap16;
        (m0 == TTC_MODE_16 && inc0 && {th0, tl0} == {BYTE_ONES, BYTE_ONES})
            ##0 s_no_wr0 |-> ovf0 ##1 ({th0, tl0} == 16'h0000 &&
                                       timer0_overflow_flag);
    endproperty
    a_wrap16: assert property (p_wrap16) // RULE15
        else $error("16-bit wrap or overflow wrong");
endmodule : ttc_top

// File: ttc_pin_model.sv
/*
 External pin model for the timer/counter: count pins and gate pins.
 Assumes the bench commands toggling and gate levels off the falling edge.
*/
`timescale 1ns/100ps
module ttc_pin_model
    import ttc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [2:0] toggle_en,
    input  wire logic [1:0] gate_lvl,
    output ttc_pins_t       pins
);
    logic [2:0] toggle_q = 3'h0;
    logic [2:0] cnt_lvl  = 3'h0;
    // Latch the command so the falling edge never races the bench
    always @(posedge clk) toggle_q <= toggle_en;
    // Each count level stands one full machine cycle
    always @(negedge clk) cnt_lvl <= cnt_lvl ^ toggle_q;
    // Gate pins follow the commanded levels
    assign pins = '{count_pin: cnt_lvl, ext_irq1_pin: gate_lvl[1],
                    ext_irq0_pin: gate_lvl[0]};
endmodule : ttc_pin_model

// File: triple_timer_counter_tb_top.sv
/*
 Self-checking bench for the triple timer/counter.
 Assumes registered read data one cycle after the address is presented.
*/
`timescale 1ns/100ps
module triple_timer_counter_tb_top
    import ttc_pkg::*;
;
    logic         clk = 1'b0;
    logic         reset_n;
    ttc_sfr_req_t sfr_req;
    logic [7:0]   sfr_rdata;
    ttc_pins_t    pins;
    logic         isr_ack_t0;
    logic         isr_ack_t1;
    logic [2:0]   flag;
    logic [2:0]   flg;
    logic [1:0]   pulse;
    logic [1:0]   pls;
    logic [2:0]   toggle_en;
    logic [1:0]   gate_lvl;
    logic [7:0]   d;
    int           fail_count = 0;
    int           n_compared = 0;
    int           cyc = 0;

    ttc_top #(.PRESCALE_BITS(5)) DUT (
        .clk(clk), .reset_n(reset_n), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .pins(pins), .isr_ack_t0(isr_ack_t0),
        .isr_ack_t1(isr_ack_t1), .timer0_overflow_flag(flag[0]),
        .timer1_overflow_flag(flag[1]), .timer2_overflow_flag(flag[2]),
        .timer1_ovf_pulse(pulse[0]), .timer2_ovf_pulse(pulse[1]));

    ttc_pin_model u_pins (.clk(clk), .toggle_en(toggle_en),
                          .gate_lvl(gate_lvl), .pins(pins));

    // Clock of 50 ns and a cycle ceiling against hangs
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        sfr_req = '{wr: 1'b1, addr: a, wdata: v};
        @(negedge clk);
        sfr_req.wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        sfr_req.addr = a;
        @(posedge clk);
        #1 d = sfr_rdata;
    endtask : rd

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        check(d, exp);
    endtask : chk_rd

    // Run for exactly n counting edges, flags captured before the stop
    task automatic run(input logic [7:0] a, input logic [7:0] on, int n);
        wr(a, on);
        repeat (n - 2) @(negedge clk);
        flg = flag;
        pls = pulse;
        wr(a, 8'h00);
    endtask : run

    task automatic t_reset;
        chk_rd(ADDR_T01_MODE, MODE_RST);
        chk_rd(ADDR_T01_CTRL, CTRL_RST);
        chk_rd(8'h80, RD_NONE);
        wr(ADDR_T01_MODE, 8'hA5);
        chk_rd(ADDR_T01_MODE, 8'hA5);
    endtask : t_reset

    task automatic t_16bit;
        wr(ADDR_T01_MODE, 8'h01);
        wr(ADDR_T0_LOW, 8'hF0);
        wr(ADDR_T0_HIGH, 8'hFF);
        run(ADDR_T01_CTRL, 8'h10, 20);
        check({7'h00, flg[0]}, 8'h01);
        chk_rd(ADDR_T0_LOW, 8'h04);
        chk_rd(ADDR_T0_HIGH, 8'h00);
    endtask : t_16bit

    task automatic t_13bit;
        wr(ADDR_T01_MODE, 8'h00);
        wr(ADDR_T0_LOW, 8'h00);
        wr(ADDR_T0_HIGH, 8'h00);
        run(ADDR_T01_CTRL, 8'h10, 70);
        rd(ADDR_T0_LOW);
        check(d & 8'h1F, 8'h06);
        chk_rd(ADDR_T0_HIGH, 8'h02);
    endtask : t_13bit

    task automatic t_reload;
        wr(ADDR_T01_MODE, 8'h02);
        wr(ADDR_T0_HIGH, 8'hF0);
        wr(ADDR_T0_LOW, 8'hFE);
        run(ADDR_T01_CTRL, 8'h10, 5);
        check({7'h00, flg[0]}, 8'h01);
        chk_rd(ADDR_T0_LOW, 8'hF3);
        chk_rd(ADDR_T0_HIGH, 8'hF0);
    endtask : t_reload

    task automatic t_split;
        wr(ADDR_T01_MODE, 8'h33);
        wr(ADDR_T0_LOW, 8'h00);
        wr(ADDR_T0_HIGH, 8'h00);
        wr(ADDR_T1_LOW, 8'h55);
        run(ADDR_T01_CTRL, 8'h10, 10);
        run(ADDR_T01_CTRL, 8'h40, 7);
        chk_rd(ADDR_T0_LOW, 8'h0A);
        chk_rd(ADDR_T0_HIGH, 8'h07);
        chk_rd(ADDR_T1_LOW, 8'h55);
    endtask : t_split

    task automatic t_gate;
        wr(ADDR_T01_MODE, 8'h09);
        wr(ADDR_T0_LOW, 8'h00);
        gate_lvl = 2'b00;
        run(ADDR_T01_CTRL, 8'h10, 10);
        chk_rd(ADDR_T0_LOW, 8'h00);
        @(negedge clk) gate_lvl = 2'b01;
        run(ADDR_T01_CTRL, 8'h10, 10);
        chk_rd(ADDR_T0_LOW, 8'h0A);
    endtask : t_gate

    task automatic t_counter;
        wr(ADDR_T01_MODE, 8'h05);
        wr(ADDR_T0_LOW, 8'h00);
        wr(ADDR_T01_CTRL, 8'h10);
        toggle_en = 3'b001;
        repeat (12) @(negedge clk);
        toggle_en = 3'b000;
        repeat (4) @(negedge clk);
        wr(ADDR_T01_CTRL, 8'h00);
        chk_rd(ADDR_T0_LOW, 8'h06);
    endtask : t_counter

    task automatic t_ack;
        wr(ADDR_T01_MODE, 8'h10);
        wr(ADDR_T1_LOW, 8'hFE);
        wr(ADDR_T1_HIGH, 8'hFF);
        wr(ADDR_T01_CTRL, 8'h60);
        repeat (2) @(negedge clk);
        check({7'h00, pulse[0]}, 8'h01);
        @(negedge clk);
        check({7'h00, pulse[0]}, 8'h00);
        @(negedge clk);
        check({7'h00, flag[1]}, 8'h01);
        check({7'h00, flag[0]}, 8'h01);
        isr_ack_t1 = 1'b1;
        isr_ack_t0 = 1'b1;
        @(negedge clk);
        isr_ack_t1 = 1'b0;
        isr_ack_t0 = 1'b0;
        @(negedge clk);
        check({7'h00, flag[1]}, 8'h00);
        check({7'h00, flag[0]}, 8'h00);
        wr(ADDR_T01_CTRL, 8'h00);
    endtask : t_ack

    task automatic t_timer2;
        wr(ADDR_T2_RLD_L, 8'h34);
        wr(ADDR_T2_RLD_H, 8'h12);
        wr(ADDR_T2_LOW, 8'hFE);
        wr(ADDR_T2_HIGH, 8'hFF);
        run(ADDR_T2_CTRL, 8'h04, 4);
        check({7'h00, flg[2]}, 8'h01);
        check({7'h00, pls[1]}, 8'h01);
        chk_rd(ADDR_T2_LOW, 8'h36);
        chk_rd(ADDR_T2_HIGH, 8'h12);
    endtask : t_timer2

    task automatic wrap_up;
        $display("Compared %0d, failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    // Reset for two cycles, then each scenario in turn
    initial begin
        reset_n = 1'b0;
        sfr_req = '0;
        isr_ack_t0 = 1'b0;
        isr_ack_t1 = 1'b0;
        toggle_en = 3'b000;
        gate_lvl = 2'b00;
        repeat (2) @(posedge clk);
        @(negedge clk) reset_n = 1'b1;
        t_reset();
        t_16bit();
        t_13bit();
        t_reload();
        t_split();
        t_gate();
        t_counter();
        t_ack();
        t_timer2();
        wrap_up();
    end
endmodule : triple_timer_counter_tb_top
